// >>> bpsc_top.sv
// Purpose: Pulse-skip control of main buck and external FET buck
// Assumes: Sense inputs are asynchronous pins
// Notes: APB slave, zero-wait answers
`timescale 1ns/1ps
module bpsc_top #(
   parameter int unsigned UV_CYC = bpsc_pkg::UV_DEGLITCH_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire bpsc_pkg::bpsc_sense_t main_sense,
   input wire bpsc_pkg::bpsc_sense_t ctrl_sense,
   input wire logic low_power_req,
   output logic main_switch_on,
   output logic ctrl_gate_on,
   output logic [1:0] main_fb_ref_select,
   output logic [1:0] ctrl_fb_ref_select,
   output logic main_ilim_select,
   output logic system_reset_out_n,
   output logic internal_enable,
   output logic irq
);
   localparam int unsigned W = bpsc_pkg::PWM_CNT_W;
   localparam logic [W-1:0] LAST = W'(bpsc_pkg::PWM_PERIOD - 1);
   localparam logic [15:0] UV_FULL = 16'(UV_CYC);

   function automatic logic [W-1:0] duty_cycles(input logic ch, input logic [1:0] sel);
      int unsigned pm;
      pm = ch ? bpsc_pkg::CTRL_DUTY_PM[sel] : bpsc_pkg::MAIN_DUTY_PM[sel];
      return W'(pm * bpsc_pkg::PWM_PERIOD / 1000);
   endfunction : duty_cycles

   // Pin synchronisers
   logic [6:0] sync1_q;
   logic [6:0] sync2_q;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sync1_q <= 7'h12;
         sync2_q <= 7'h12;
      end
      else
      begin
         sync1_q <= {low_power_req, main_sense, ctrl_sense};
         sync2_q <= sync1_q;
      end
   end
   bpsc_pkg::bpsc_sense_t main_s;
   bpsc_pkg::bpsc_sense_t ctrl_s;
   logic lp_s;
   assign lp_s = sync2_q[6];
   assign main_s = sync2_q[5:3];
   assign ctrl_s = sync2_q[2:0];

   // Registers
   logic [1:0] main_ref_q, main_ref_d, ctrl_ref_q, ctrl_ref_d;
   logic [1:0] main_duty_q, main_duty_d, ctrl_duty_q, ctrl_duty_d;
   logic ilim_q, ilim_d, main_en_q, main_en_d, ctrl_en_q, ctrl_en_d;
   logic [bpsc_pkg::EV_W-1:0] stat_q, stat_d, mask_q, mask_d, ev_set;
   logic [31:0] prdata_d;
   logic pready_d, pslverr_d, irq_d, wr, mapped;
   logic [31:0] status_word;
   assign wr = psel && penable && pwrite && pready;

   always_comb
   begin
      mapped = 1'b1;
      prdata_d = 32'h0000_0000;
      unique case (paddr)
         bpsc_pkg::ADDR_MAIN_CFG: prdata_d = 32'({main_en_q, ilim_q, main_duty_q, main_ref_q});
         bpsc_pkg::ADDR_CTRL_CFG: prdata_d = 32'({ctrl_en_q, 1'b0, ctrl_duty_q, ctrl_ref_q});
         bpsc_pkg::ADDR_STATUS: prdata_d = status_word;
         bpsc_pkg::ADDR_EV_STAT: prdata_d = 32'(stat_q);
         bpsc_pkg::ADDR_EV_MASK: prdata_d = 32'(mask_q);
         default: mapped = 1'b0;
      endcase
   end

   always_comb
   begin
      pready_d = psel && !penable;
      pslverr_d = psel && !penable && !mapped;
      main_ref_d = main_ref_q;
      main_duty_d = main_duty_q;
      ilim_d = ilim_q;
      main_en_d = main_en_q;
      ctrl_ref_d = ctrl_ref_q;
      ctrl_duty_d = ctrl_duty_q;
      ctrl_en_d = ctrl_en_q;
      mask_d = mask_q;
      stat_d = stat_q | ev_set;
      if (wr && paddr == bpsc_pkg::ADDR_MAIN_CFG)
      begin
         main_ref_d = pwdata[bpsc_pkg::F_FBREF +: 2];
         main_duty_d = pwdata[bpsc_pkg::F_DUTY +: 2];
         ilim_d = pwdata[bpsc_pkg::F_ILIM];
         main_en_d = pwdata[bpsc_pkg::F_EN];
      end
      if (wr && paddr == bpsc_pkg::ADDR_CTRL_CFG)
      begin
         ctrl_ref_d = pwdata[bpsc_pkg::F_FBREF +: 2];
         ctrl_duty_d = pwdata[bpsc_pkg::F_DUTY +: 2];
         ctrl_en_d = pwdata[bpsc_pkg::F_EN];
      end
      if (wr && paddr == bpsc_pkg::ADDR_EV_STAT)
      begin
         stat_d = (stat_q & ~pwdata[bpsc_pkg::EV_W-1:0]) | ev_set;
      end
      if (wr && paddr == bpsc_pkg::ADDR_EV_MASK)
      begin
         mask_d = pwdata[bpsc_pkg::EV_W-1:0];
      end
      irq_d = |(stat_q & mask_q);
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         main_ref_q <= bpsc_pkg::FBREF_RST;
         main_duty_q <= bpsc_pkg::DUTY_RST;
         ilim_q <= bpsc_pkg::ILIM_RST;
         main_en_q <= bpsc_pkg::MAIN_EN_RST;
         ctrl_ref_q <= bpsc_pkg::FBREF_RST;
         ctrl_duty_q <= bpsc_pkg::DUTY_RST;
         ctrl_en_q <= bpsc_pkg::CTRL_EN_RST;
         stat_q <= 3'h0;
         mask_q <= 3'h0;
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
         irq <= 1'b0;
      end
      else
      begin
         main_ref_q <= main_ref_d;
         main_duty_q <= main_duty_d;
         ilim_q <= ilim_d;
         main_en_q <= main_en_d;
         ctrl_ref_q <= ctrl_ref_d;
         ctrl_duty_q <= ctrl_duty_d;
         ctrl_en_q <= ctrl_en_d;
         stat_q <= stat_d;
         mask_q <= mask_d;
         prdata <= prdata_d;
         pready <= pready_d;
         pslverr <= pslverr_d;
         irq <= irq_d;
      end
   end
   assign main_fb_ref_select = main_ref_q;
   assign ctrl_fb_ref_select = ctrl_ref_q;
   assign main_ilim_select = ilim_q;

   // Switching period counter
   logic [W-1:0] cnt_q, cnt_d;
   always_comb
   begin
      cnt_d = (cnt_q == LAST) ? '0 : cnt_q + 1'b1;
   end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cnt_q <= '0;
      else
         cnt_q <= cnt_d;
   end

   // Pulse-skip channels: 0 main, 1 controller
   logic [1:0] ch_en, ch_fb, ch_il, ch_pulse;
   logic [W-1:0] ch_duty [2];
   assign ch_en = {ctrl_en_q && !lp_s, main_en_q && !lp_s};
   assign ch_fb = {ctrl_s.fb_below, main_s.fb_below};
   assign ch_il = {ctrl_s.ilim, main_s.ilim};
   assign ch_duty[0] = duty_cycles(1'b0, main_duty_q);
   assign ch_duty[1] = duty_cycles(1'b1, ctrl_duty_q);
   for (genvar i = 0; i < 2; i++)
   begin : g_ch
      logic pulse_q;
      logic pulse_d;
      always_comb
      begin
         pulse_d = pulse_q;
         if (!ch_en[i])
            pulse_d = 1'b0;
         else if (cnt_q == '0)
            pulse_d = ch_fb[i] && !ch_il[i] && ch_duty[i] != '0;
         else if (ch_il[i] || cnt_q >= ch_duty[i])
            pulse_d = 1'b0;
      end
      always_ff @(posedge pclk or negedge presetn)
      begin
         if (!presetn)
            pulse_q <= 1'b0;
         else
            pulse_q <= pulse_d;
      end
      assign ch_pulse[i] = pulse_q;
   end
   assign main_switch_on = ch_pulse[0];
   assign ctrl_gate_on = ch_pulse[1];

   // Undervoltage deglitch and supervisor
   logic [15:0] uv_cnt_q, uv_cnt_d;
   logic [1:0] uv_prev_q;
   bpsc_pkg::bpsc_seq_t seq_q, seq_d;
   logic rst_n_q, rst_n_d, ien_q, ien_d, uv_trip;
   assign uv_trip = uv_cnt_q == UV_FULL;
   always_comb
   begin
      uv_cnt_d = !main_s.uv ? 16'h0000 : (uv_trip ? uv_cnt_q : uv_cnt_q + 16'h0001);
      seq_d = seq_q;
      unique case (seq_q)
         bpsc_pkg::SEQ_HOLD: if (!main_s.uv && !lp_s) seq_d = bpsc_pkg::SEQ_RUN;
         bpsc_pkg::SEQ_RUN: if (uv_trip || lp_s) seq_d = bpsc_pkg::SEQ_HOLD;
      endcase
      rst_n_d = seq_d == bpsc_pkg::SEQ_RUN;
      ien_d = seq_d == bpsc_pkg::SEQ_RUN;
      ev_set = '0;
      ev_set[bpsc_pkg::EV_MAIN_UV] = main_s.uv && !uv_prev_q[0];
      ev_set[bpsc_pkg::EV_CTRL_UV] = ctrl_s.uv && !uv_prev_q[1];
      ev_set[bpsc_pkg::EV_SYSRST] = seq_q == bpsc_pkg::SEQ_RUN && uv_trip;
   end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         uv_cnt_q <= 16'h0000;
         uv_prev_q <= 2'h3;
         seq_q <= bpsc_pkg::SEQ_HOLD;
         rst_n_q <= 1'b0;
         ien_q <= 1'b0;
      end
      else
      begin
         uv_cnt_q <= uv_cnt_d;
         uv_prev_q <= {ctrl_s.uv, main_s.uv};
         seq_q <= seq_d;
         rst_n_q <= rst_n_d;
         ien_q <= ien_d;
      end
   end
   assign system_reset_out_n = rst_n_q;
   assign internal_enable = ien_q;
   always_comb
   begin
      status_word = 32'h0000_0000;
      status_word[bpsc_pkg::ST_MAIN_UV] = main_s.uv;
      status_word[bpsc_pkg::ST_CTRL_UV] = ctrl_s.uv;
      status_word[bpsc_pkg::ST_READY] = ien_q;
      status_word[bpsc_pkg::ST_LOWPWR] = lp_s;
   end

   // Checks
   sequence s_start0;
      cnt_q == '0 && ch_en[0] && ch_fb[0] && !ch_il[0];
   endsequence
   property p_start;
      @(posedge pclk) disable iff (!presetn) s_start0 |=> main_switch_on;
   endproperty
   a_start: assert property (p_start) else $error("Pulse not started");
   property p_skip;
      @(posedge pclk) disable iff (!presetn) cnt_q == '0 && !ch_fb[0] |=> !main_switch_on;
   endproperty
   a_skip: assert property (p_skip) else $error("Cycle not skipped");
   property p_ilim;
      @(posedge pclk) disable iff (!presetn) main_switch_on && ch_il[0] && cnt_q != '0 |=> !main_switch_on;
   endproperty
   a_ilim: assert property (p_ilim) else $error("Current limit ignored");
   property p_main_len;
      @(posedge pclk) disable iff (!presetn)
         $fell(main_switch_on) |-> $past(ch_il[0]) || !$past(ch_en[0]) || $past(cnt_q) >= $past(ch_duty[0]);
   endproperty
   a_main_len: assert property (p_main_len) else $error("Main pulse length wrong");
   property p_period;
      @(posedge pclk) disable iff (!presetn) cnt_q == LAST |=> cnt_q == '0 ##1 cnt_q == W'(1);
   endproperty
   a_period: assert property (p_period) else $error("Switching period wrong");
   property p_lowpwr;
      @(posedge pclk) disable iff (!presetn) lp_s |=> !main_switch_on;
   endproperty
   a_lowpwr: assert property (p_lowpwr) else $error("Main on in low power");
   property p_trip;
      @(posedge pclk) disable iff (!presetn) seq_q == bpsc_pkg::SEQ_RUN && uv_trip |=> !system_reset_out_n;
   endproperty
   a_trip: assert property (p_trip) else $error("Reset not asserted");
   property p_filter;
      @(posedge pclk) disable iff (!presetn)
         $fell(system_reset_out_n) |-> $past(uv_trip) || $past(lp_s);
   endproperty
   a_filter: assert property (p_filter) else $error("Reset before filter");
   property p_good;
      @(posedge pclk) disable iff (!presetn) $rose(internal_enable) |-> !$past(main_s.uv);
   endproperty
   a_good: assert property (p_good) else $error("Enabled while undervoltage");
   property p_ctrl_off;
      @(posedge pclk) disable iff (!presetn) !ctrl_en_q |=> !ctrl_gate_on;
   endproperty
   a_ctrl_off: assert property (p_ctrl_off) else $error("Controller ran disabled");
   property p_latch;
      @(posedge pclk) disable iff (!presetn) $rose(main_s.uv) |=> stat_q[bpsc_pkg::EV_MAIN_UV] [*2];
   endproperty
   a_latch: assert property (p_latch) else $error("Undervoltage not latched");
endmodule : bpsc_top

// >>> bpsc_pkg.sv
// Purpose: Constants and types for the buck pulse-skip control block
// Assumes: 25 MHz pclk, APB register access
// Notes: Operation list below
// Operation
// - Device waits for main output good before enabling internal functions.
// - Long main undervoltage puts device into reset, reset output low.
// - Main feedback reference selectable from four values by register field.
// - Controller feedback reference selectable from four values by its field.
// - Both regulators switch from an internal 250 kHz period.
// - Feedback sampled each cycle start; below target gives full pulse, else skip.
// - Only a current-limit event ends a started pulse early; code also ends it on channel disable or low power.
// - Main duty field: 12, 15, 26 (default), 63.5 percent.
// - Current-limit select bit: 0 gives 3.3 A default, 1 gives 2.3 A.
// - Main regulator is off in low power mode.
// - Software may disable main regulator; its undervoltage still counts as fault.
// - Controller starts disabled and runs only after software enables it.
// - Controller duty field: 9, 12, 22.5 (default), 58 percent.
// - Each undervoltage readable as live status and sticky latched flag.
package bpsc_pkg;
   localparam int unsigned CLK_HZ = 25_000_000;
   localparam int unsigned CLK_NS = 40;
   localparam int unsigned PWM_HZ = 250_000;
   localparam int unsigned PWM_PERIOD = CLK_HZ / PWM_HZ;
   localparam int unsigned PWM_CNT_W = 7;
   localparam int unsigned T_UV_DEGLITCH_NS = 20_000;
   localparam int unsigned UV_DEGLITCH_CYC = (T_UV_DEGLITCH_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned MAIN_DUTY_PM [4] = '{120, 150, 260, 635};
   localparam int unsigned CTRL_DUTY_PM [4] = '{90, 120, 225, 580};
   localparam logic [7:0] ADDR_MAIN_CFG = 8'h00;
   localparam logic [7:0] ADDR_CTRL_CFG = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [7:0] ADDR_EV_STAT = 8'h0c;
   localparam logic [7:0] ADDR_EV_MASK = 8'h10;
   localparam int unsigned F_FBREF = 0;
   localparam int unsigned F_DUTY = 2;
   localparam int unsigned F_ILIM = 4;
   localparam int unsigned F_EN = 5;
   localparam logic [1:0] FBREF_RST = 2'h0;
   localparam logic [1:0] DUTY_RST = 2'h2;
   localparam logic ILIM_RST = 1'h0;
   localparam logic MAIN_EN_RST = 1'h1;
   localparam logic CTRL_EN_RST = 1'h0;
   localparam int unsigned ST_MAIN_UV = 0;
   localparam int unsigned ST_CTRL_UV = 1;
   localparam int unsigned ST_READY = 2;
   localparam int unsigned ST_LOWPWR = 3;
   localparam int unsigned EV_MAIN_UV = 0;
   localparam int unsigned EV_CTRL_UV = 1;
   localparam int unsigned EV_SYSRST = 2;
   localparam int unsigned EV_W = 3;
   typedef struct packed {
      logic fb_below;
      logic uv;
      logic ilim;
   } bpsc_sense_t;
   typedef enum {SEQ_HOLD, SEQ_RUN} bpsc_seq_t;
endpackage : bpsc_pkg

// >>> bpsc_load_model.sv
// Purpose: Inductor, switch and divider seen by one regulator
// Assumes: Level rises while switch on, decays while off
// Notes: fb_mode 1 forces below target, 2 above
`timescale 1ns/1ps
module bpsc_load_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic switch_on,
   input wire logic [1:0] fb_mode,
   input wire logic uv_force,
   input wire logic ilim_force,
   output bpsc_pkg::bpsc_sense_t sense
);
   int lvl_q;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         lvl_q <= 0;
      else if (switch_on)
         lvl_q <= (lvl_q > 992) ? 1000 : lvl_q + 8;
      else if (lvl_q > 0)
         lvl_q <= lvl_q - 1;
   end
   assign sense = {(fb_mode == 2'h1) | ((fb_mode == 2'h0) & (lvl_q < 500)), uv_force | (lvl_q < 200), ilim_force};
endmodule : bpsc_load_model

// >>> bpsc_tb_top.sv
// Purpose: Self-checking bench for buck pulse-skip control
// Assumes: UV_CYC shortened to 8
// Notes: Loads come from bpsc_load_model
`timescale 1ns/1ps
module bpsc_tb_top;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic low_power_req = 1'b0;
   logic [1:0] m_fb = 2'h0;
   logic [1:0] c_fb = 2'h0;
   logic m_uv = 1'b0;
   logic m_il = 1'b0;
   logic [31:0] prdata, rd, d;
   logic pready, pslverr, serr, main_switch_on, ctrl_gate_on, main_ilim_select;
   logic system_reset_out_n, internal_enable, irq;
   logic [1:0] main_fb_ref_select, ctrl_fb_ref_select;
   bpsc_pkg::bpsc_sense_t main_sense, ctrl_sense;
   int error_cnt = 0;
   int checks_done = 0;
   int cyc = 0;
   int w, p, n;
   always #20 pclk = ~pclk;
   bpsc_top #(.UV_CYC(8)) bpsc_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .main_sense(main_sense), .ctrl_sense(ctrl_sense), .low_power_req(low_power_req),
      .main_switch_on(main_switch_on), .ctrl_gate_on(ctrl_gate_on), .main_fb_ref_select(main_fb_ref_select),
      .ctrl_fb_ref_select(ctrl_fb_ref_select), .main_ilim_select(main_ilim_select),
      .system_reset_out_n(system_reset_out_n), .internal_enable(internal_enable), .irq(irq));
   bpsc_load_model main_load (.pclk(pclk), .presetn(presetn), .switch_on(main_switch_on), .fb_mode(m_fb),
      .uv_force(m_uv), .ilim_force(m_il), .sense(main_sense));
   bpsc_load_model ctrl_load (.pclk(pclk), .presetn(presetn), .switch_on(ctrl_gate_on), .fb_mode(c_fb),
      .uv_force(1'b0), .ilim_force(1'b0), .sense(ctrl_sense));
   task automatic conclude();
      if (error_cnt == 0 && checks_done > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : conclude
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      rd = prdata;
      serr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   function automatic logic sig(input int s);
      case (s)
         0: return main_switch_on;
         1: return ctrl_gate_on;
         default: return system_reset_out_n;
      endcase
   endfunction : sig
   task automatic wt(input int s, input logic v, input int lim, output int cnt);
      cnt = 0;
      while (sig(s) !== v && cnt < lim)
      begin
         @(posedge pclk);
         cnt++;
      end
   endtask : wt
   task automatic meas(input int s);
      wt(s, 1'b1, 400, p);
      wt(s, 1'b0, 200, w);
      wt(s, 1'b1, 400, p);
      p = p + w;
   endtask : meas
   task automatic t_start();
      chk(internal_enable, 1'b0);
      wt(2, 1'b1, 3000, n);
      chk({main_sense.uv, system_reset_out_n, internal_enable}, 3'h3);
      apb(1'b0, bpsc_pkg::ADDR_MAIN_CFG, 0);
      chk(rd, {26'h0, bpsc_pkg::MAIN_EN_RST, bpsc_pkg::ILIM_RST, bpsc_pkg::DUTY_RST, bpsc_pkg::FBREF_RST});
      apb(1'b0, bpsc_pkg::ADDR_CTRL_CFG, 0);
      chk(rd, {26'h0, bpsc_pkg::CTRL_EN_RST, 1'b0, bpsc_pkg::DUTY_RST, bpsc_pkg::FBREF_RST});
      c_fb <= 2'h1;
      meas(1);
      chk(w, 0);
      apb(1'b0, 8'h14, 0);
      chk(serr, 1'b1);
      chk(rd, 32'h0000_0000);
   endtask : t_start
   task automatic t_duty();
      m_fb <= 2'h1;
      for (int c = 0; c < 2; c++)
         for (int i = 0; i < 4; i++)
         begin
            d = 32'h20 | (i << 2) | i | ((c == 0) ? ((i & 1) << 4) : 0);
            apb(1'b1, c ? bpsc_pkg::ADDR_CTRL_CFG : bpsc_pkg::ADDR_MAIN_CFG, d);
            apb(1'b0, c ? bpsc_pkg::ADDR_CTRL_CFG : bpsc_pkg::ADDR_MAIN_CFG, 0);
            chk(rd, d);
            meas(c);
            meas(c);
            chk(w, (c ? bpsc_pkg::CTRL_DUTY_PM[i] : bpsc_pkg::MAIN_DUTY_PM[i]) * bpsc_pkg::PWM_PERIOD / 1000);
            chk(p, bpsc_pkg::PWM_PERIOD);
            chk(c ? ctrl_fb_ref_select : main_fb_ref_select, i);
            if (c == 0)
               chk(main_ilim_select, i & 1);
         end
      apb(1'b1, bpsc_pkg::ADDR_CTRL_CFG, 0);
   endtask : t_duty
   task automatic t_skip();
      m_fb <= 2'h2;
      repeat (bpsc_pkg::PWM_PERIOD + 4) @(posedge pclk);
      meas(0);
      chk(w, 0);
      m_fb <= 2'h1;
      apb(1'b1, bpsc_pkg::ADDR_MAIN_CFG, 32'h2c);
      meas(0);
      repeat (10) @(posedge pclk);
      m_il <= 1'b1;
      wt(0, 1'b0, 80, n);
      chk(n < 6, 1'b1);
      meas(0);
      chk(w, 0);
      m_il <= 1'b0;
      meas(0);
      meas(0);
      chk(w, 63);
   endtask : t_skip
   task automatic t_uv();
      apb(1'b1, bpsc_pkg::ADDR_EV_MASK, 0);
      apb(1'b1, bpsc_pkg::ADDR_EV_STAT, 7);
      m_uv <= 1'b1;
      repeat (4) @(posedge pclk);
      m_uv <= 1'b0;
      wt(2, 1'b0, 30, n);
      chk(system_reset_out_n, 1'b1);
      apb(1'b1, bpsc_pkg::ADDR_MAIN_CFG, 32'h08);
      wt(2, 1'b0, 2000, n);
      chk({system_reset_out_n, internal_enable}, 0);
      apb(1'b0, bpsc_pkg::ADDR_STATUS, 0);
      chk(rd[0], 1'b1);
      apb(1'b0, bpsc_pkg::ADDR_EV_STAT, 0);
      chk({irq, rd[2], rd[0]}, 3'h3);
      apb(1'b1, bpsc_pkg::ADDR_EV_MASK, 1);
      repeat (2) @(posedge pclk);
      chk(irq, 1'b1);
      apb(1'b1, bpsc_pkg::ADDR_MAIN_CFG, 32'h28);
      wt(2, 1'b1, 3000, n);
      chk({system_reset_out_n, internal_enable}, 3);
      apb(1'b0, bpsc_pkg::ADDR_STATUS, 0);
      chk(rd[0], 1'b0);
      apb(1'b0, bpsc_pkg::ADDR_EV_STAT, 0);
      chk(rd[0], 1'b1);
      apb(1'b1, bpsc_pkg::ADDR_EV_STAT, 7);
      repeat (2) @(posedge pclk);
      chk(irq, 1'b0);
   endtask : t_uv
   task automatic t_lowpwr();
      low_power_req <= 1'b1;
      wt(2, 1'b0, 50, n);
      chk(system_reset_out_n, 1'b0);
      meas(0);
      chk(w, 0);
      apb(1'b0, bpsc_pkg::ADDR_STATUS, 0);
      chk(rd[3], 1'b1);
      low_power_req <= 1'b0;
      wt(2, 1'b1, 3000, n);
      chk(system_reset_out_n, 1'b1);
   endtask : t_lowpwr
   always @(posedge pclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 40000)
      begin
         error_cnt++;
         conclude();
      end
   end
   initial
   begin
      repeat (2) @(posedge pclk);
      chk({system_reset_out_n, internal_enable, main_switch_on, ctrl_gate_on}, 0);
      presetn <= 1'b1;
      @(posedge pclk);
      t_start();
      t_duty();
      t_skip();
      t_uv();
      t_lowpwr();
      conclude();
   end
endmodule : bpsc_tb_top
